// ===== rtl/mtc_defines.svh
/*
 * Constants of the microsecond timer and calendar: register offsets,
 * reset values and timing counts.
 * Assumes a 50 MHz system clock and a byte-addressed plain register port.
 */
// How it works
// [RULE1] A free-running counter steps by one every microsecond on its own and software can read it.
// [RULE2] A software write loads the counter, which then counts upward from the loaded value.
// [RULE3] The counter wraps silently from all ones to zero so signed differences stay correct.
// [RULE4] The hour field counts 0 to 23 and software can read and overwrite it.
// [RULE5] The minute field counts 0 to 59 and a software write replaces it.
// [RULE6] The seconds field counts 0 to 59 and software can read and overwrite it.
// [RULE7] The month field runs 1 to 12 and software can read and set it.
// [RULE8] The day of month starts at 1 and ends at 28, 29, 30 or 31 by month and leap year.
// [RULE9] The weekday field holds Sunday as 0 up to Saturday as 6.
// [RULE10] Writing the year recomputes the weekday from a fixed reference instead of a direct write.
// [RULE11] Writing the year also recomputes the day of year, so software writes the year last.
// [RULE12] The calendar steps once a second and each field carries into the next past its maximum.
`ifndef MTC_DEFINES_SVH
`define MTC_DEFINES_SVH

`define MTC_ADDR_W      8
`define MTC_OFS_TIMER   8'h00
`define MTC_OFS_SEC     8'h04
`define MTC_OFS_MIN     8'h08
`define MTC_OFS_HOUR    8'h0c
`define MTC_OFS_DAY     8'h10
`define MTC_OFS_MONTH   8'h14
`define MTC_OFS_YEAR    8'h18
`define MTC_OFS_WDAY    8'h1c
`define MTC_OFS_YDAY    8'h20

`define MTC_RST_YEAR    12'h7d0
`define MTC_RST_MONTH   4'h1
`define MTC_RST_DAY     5'h01
`define MTC_RST_WDAY    3'h6
`define MTC_RST_YDAY    9'h001

`define MTC_CLK_NS      20
`define MTC_US_NS       1000
`define MTC_US_CYCLES   ((`MTC_US_NS + `MTC_CLK_NS - 1) / `MTC_CLK_NS)
`define MTC_US_PER_SEC  1000000

`endif

// ===== rtl/mtc_pkg.sv
/*
 * Types of the microsecond timer and calendar.
 * Assumes mtc_defines.svh supplies all numeric constants.
 */
package mtc_pkg;
	typedef logic [5:0]  mtc_sixty_t;
	typedef logic [4:0]  mtc_hour_t;
	typedef logic [4:0]  mtc_day_t;
	typedef logic [3:0]  mtc_month_t;
	typedef logic [11:0] mtc_year_t;
	typedef logic [2:0]  mtc_wday_t;
	typedef logic [8:0]  mtc_yday_t;

	// Whole calendar state, carried out of the block as one word.
	typedef struct packed {
		mtc_year_t  year;
		mtc_month_t clock_month_field;
		mtc_day_t   day;
		mtc_hour_t  hour;
		mtc_sixty_t minute;
		mtc_sixty_t second;
		mtc_wday_t  clock_weekday_field;
		mtc_yday_t  yday;
	} mtc_cal_t;
endpackage

// ===== rtl/mtc_top.sv
/*
 * Microsecond timer and calendar clock with a plain register port.
 * Assumes strobes one cycle long, never both at once, synchronous to mclk_in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mtc_defines.svh"

module mtc_top #(
	parameter int TIMER_W    = 32,
	parameter int US_PER_SEC = `MTC_US_PER_SEC
) (
	input  wire logic                    mclk_in,
	input  wire logic                    srst_in,
	input  wire logic [`MTC_ADDR_W-1:0]  bus_addr_in,
	input  wire logic [31:0]             bus_wdata_in,
	input  wire logic                    bus_wr_in,
	input  wire logic                    bus_rd_in,
	output logic      [31:0]             bus_rdata_out,
	output logic      [TIMER_W-1:0]      timer_out,
	output mtc_pkg::mtc_cal_t            calendar_out,
	output logic                         us_tick_out,
	output logic                         sec_tick_out
);
	import mtc_pkg::*;

	// ************************************************************
	// Helper functions
	// ************************************************************

	// Gregorian leap year test.
	function automatic logic is_leap(input mtc_year_t y);
		is_leap = ((y % 12'd4) == 12'd0 && (y % 12'd100) != 12'd0)
			|| (y % 12'd400) == 12'd0;
	endfunction

	// Last day of a month; an invalid month gets the long limit.
	function automatic mtc_day_t month_len(input mtc_month_t m, input mtc_year_t y);
		case (m)
			4'd2:    month_len = is_leap(y) ? 5'd29 : 5'd28;
			4'd4,
			4'd6,
			4'd9,
			4'd11:   month_len = 5'd30;
			default: month_len = 5'd31;
		endcase
	endfunction

	// Days before the first of a month in a common year.
	function automatic logic [8:0] days_before(input mtc_month_t m);
		case (m)
			4'd2:    days_before = 9'd31;
			4'd3:    days_before = 9'd59;
			4'd4:    days_before = 9'd90;
			4'd5:    days_before = 9'd120;
			4'd6:    days_before = 9'd151;
			4'd7:    days_before = 9'd181;
			4'd8:    days_before = 9'd212;
			4'd9:    days_before = 9'd243;
			4'd10:   days_before = 9'd273;
			4'd11:   days_before = 9'd304;
			4'd12:   days_before = 9'd334;
			default: days_before = 9'd0;
		endcase
	endfunction

	// Day of year of a date, counting the first of January as 1.
	function automatic mtc_yday_t yday_of(input mtc_year_t y, input mtc_month_t m,
		input mtc_day_t d);
		logic [8:0] extra;
		extra = (is_leap(y) && m > 4'd2) ? 9'd1 : 9'd0;
		yday_of = days_before(m) + 9'(d) + extra;
	endfunction

	// Weekday of a date, counted in whole days from year zero of the calendar.
	// The month offset is the day count before the month, plus six from March on, modulo seven, and
	// dates in January and February count against the previous year.
	function automatic mtc_wday_t weekday_of(input mtc_year_t y, input mtc_month_t m,
		input mtc_day_t d);
		logic [15:0] yy;
		logic [15:0] sum;
		logic [15:0] moff;
		yy   = (m < 4'd3) ? 16'(y) - 16'd1 : 16'(y);
		moff = 16'((days_before(m) + ((m < 4'd3) ? 9'd0 : 9'd6)) % 9'd7);
		sum  = yy + yy / 16'd4 - yy / 16'd100 + yy / 16'd400 + moff + 16'(d);
		weekday_of = 3'(sum % 16'd7);
	endfunction

	// ************************************************************
	// Register port decode
	// ************************************************************

	logic                year_write;
	logic                hour_write;
	logic                minute_write;
	logic                seconds_write;
	logic                month_write;
	logic                day_of_month_write;
	logic                timer_write;

	// Read-only offsets decode to nothing on a write, so those writes vanish.
	assign timer_write        = bus_wr_in && bus_addr_in == `MTC_OFS_TIMER;
	assign seconds_write      = bus_wr_in && bus_addr_in == `MTC_OFS_SEC;
	assign minute_write       = bus_wr_in && bus_addr_in == `MTC_OFS_MIN;
	assign hour_write         = bus_wr_in && bus_addr_in == `MTC_OFS_HOUR;
	assign day_of_month_write = bus_wr_in && bus_addr_in == `MTC_OFS_DAY;
	assign month_write        = bus_wr_in && bus_addr_in == `MTC_OFS_MONTH;
	assign year_write         = bus_wr_in && bus_addr_in == `MTC_OFS_YEAR;

	// ************************************************************
	// Microsecond prescaler and timer
	// ************************************************************

	logic [5:0]          us_pre;
	logic                us_tick;
	logic [TIMER_W-1:0]  timer;

	assign us_tick = us_pre == 6'(`MTC_US_CYCLES - 1);

	// The prescaler ignores timer writes, so a load does not shift the phase
	// of later ticks; the first step after a load may come early by up to 1 us.
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			us_pre <= 6'h00;
		else if (us_tick)
			us_pre <= 6'h00; // see [RULE1]
		else
			us_pre <= us_pre + 6'h01;
	end

	// A write beats a tick in the same cycle; the loaded value then counts on.
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			timer <= '0;
		else if (timer_write)
			timer <= TIMER_W'(bus_wdata_in); // see [RULE2]
		else if (us_tick)
			timer <= timer + TIMER_W'(1); // see [RULE1] see [RULE3]
	end

	// ************************************************************
	// Second prescaler
	// ************************************************************

	logic [19:0]         sec_pre;
	logic                sec_tick;

	assign sec_tick = us_tick && sec_pre == 20'(US_PER_SEC - 1);

	// Counts microsecond ticks, so a timer write never disturbs the calendar.
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			sec_pre <= 20'h00000;
		else if (sec_tick)
			sec_pre <= 20'h00000; // see [RULE12]
		else if (us_tick)
			sec_pre <= sec_pre + 20'h00001;
	end

	// ************************************************************
	// Calendar
	// ************************************************************

	mtc_cal_t            cal;
	logic                sec_wrap;
	logic                min_wrap;
	logic                hour_wrap;
	logic                day_wrap;
	logic                mon_wrap;
	mtc_day_t            mlen;

	assign mlen      = month_len(cal.clock_month_field, cal.year);
	assign sec_wrap  = sec_tick && cal.second >= 6'd59;
	assign min_wrap  = sec_wrap && cal.minute >= 6'd59;
	assign hour_wrap = min_wrap && cal.hour >= 5'd23;
	assign day_wrap  = hour_wrap && cal.day >= mlen;
	assign mon_wrap  = day_wrap && cal.clock_month_field >= 4'd12;

	// A field write wins over its own step; the carry out of its old value still steps the next field.
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			cal.second              <= 6'h00;
			cal.minute              <= 6'h00;
			cal.hour                <= 5'h00;
			cal.day                 <= `MTC_RST_DAY;
			cal.clock_month_field   <= `MTC_RST_MONTH;
			cal.year                <= `MTC_RST_YEAR;
			cal.clock_weekday_field <= `MTC_RST_WDAY;
			cal.yday                <= `MTC_RST_YDAY;
		end
		else
		begin
			if (seconds_write)
				cal.second <= mtc_sixty_t'(bus_wdata_in); // see [RULE6]
			else if (sec_tick)
				cal.second <= sec_wrap ? 6'h00 : cal.second + 6'h01; // see [RULE12]

			if (minute_write)
				cal.minute <= mtc_sixty_t'(bus_wdata_in); // see [RULE5]
			else if (sec_wrap)
				cal.minute <= min_wrap ? 6'h00 : cal.minute + 6'h01;

			if (hour_write)
				cal.hour <= mtc_hour_t'(bus_wdata_in); // see [RULE4]
			else if (min_wrap)
				cal.hour <= hour_wrap ? 5'h00 : cal.hour + 5'h01;

			if (day_of_month_write)
				cal.day <= mtc_day_t'(bus_wdata_in);
			else if (hour_wrap)
				cal.day <= day_wrap ? 5'h01 : cal.day + 5'h01; // see [RULE8]

			if (month_write)
				cal.clock_month_field <= mtc_month_t'(bus_wdata_in); // see [RULE7]
			else if (day_wrap)
				cal.clock_month_field <= mon_wrap ? 4'h1 : cal.clock_month_field + 4'h1;

			if (year_write)
				cal.year <= mtc_year_t'(bus_wdata_in);
			else if (mon_wrap)
				cal.year <= cal.year + 12'h001;

			// Derived from the new year with the stored month and day.
			if (year_write)
				cal.clock_weekday_field <= weekday_of(mtc_year_t'(bus_wdata_in),
					cal.clock_month_field, cal.day); // see [RULE10]
			else if (hour_wrap)
				cal.clock_weekday_field <= (cal.clock_weekday_field >= 3'd6) ?
					3'd0 : cal.clock_weekday_field + 3'd1; // see [RULE9]

			if (year_write)
				cal.yday <= yday_of(mtc_year_t'(bus_wdata_in),
					cal.clock_month_field, cal.day); // see [RULE11]
			else if (mon_wrap)
				cal.yday <= 9'h001;
			else if (hour_wrap)
				cal.yday <= cal.yday + 9'h001;
		end
	end

	// ************************************************************
	// Read data and outputs
	// ************************************************************

	// Read data stand only in the cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge mclk_in)
	begin
		if (srst_in || !bus_rd_in)
			bus_rdata_out <= 32'h00000000;
		else
		begin
			case (bus_addr_in)
				`MTC_OFS_TIMER: bus_rdata_out <= 32'(timer); // see [RULE1]
				`MTC_OFS_SEC:   bus_rdata_out <= 32'(cal.second);
				`MTC_OFS_MIN:   bus_rdata_out <= 32'(cal.minute);
				`MTC_OFS_HOUR:  bus_rdata_out <= 32'(cal.hour);
				`MTC_OFS_DAY:   bus_rdata_out <= 32'(cal.day);
				`MTC_OFS_MONTH: bus_rdata_out <= 32'(cal.clock_month_field);
				`MTC_OFS_YEAR:  bus_rdata_out <= 32'(cal.year);
				`MTC_OFS_WDAY:  bus_rdata_out <= 32'(cal.clock_weekday_field);
				`MTC_OFS_YDAY:  bus_rdata_out <= 32'(cal.yday);
				default:        bus_rdata_out <= 32'h00000000;
			endcase
		end
	end

	// Counters and calendar are flops, so timer_out and calendar_out are registered; the tick outputs are decoded from the prescalers.
	assign timer_out    = timer;
	assign calendar_out = cal;
	assign us_tick_out  = us_tick;
	assign sec_tick_out = sec_tick;

	// ************************************************************
	// Checks
	// ************************************************************

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (srst_in);

	// Final second of a day, with no write disturbing the carry chain.
	sequence s_day_end;
		sec_tick && cal.second == 6'd59 && cal.minute == 6'd59
			&& cal.hour == 5'd23 && !bus_wr_in;
	endsequence

	// Final second of a common February.
	sequence s_feb_end;
		s_day_end ##0 cal.clock_month_field == 4'd2 && cal.day == 5'd28
			&& !is_leap(cal.year);
	endsequence

	chk_us_tick_period: assert property ( // see [RULE1]
		us_tick |=> !us_tick [*8] ##42 us_tick)
		else $error("microsecond tick not every 50 cycles");

	chk_timer_steps: assert property ( // see [RULE1]
		us_tick && !timer_write |=> timer == $past(timer) + TIMER_W'(1))
		else $error("timer did not step on microsecond tick");

	chk_timer_load: assert property ( // see [RULE2]
		timer_write |=> timer == TIMER_W'($past(bus_wdata_in)))
		else $error("timer write not loaded");

	chk_timer_wrap: assert property ( // see [RULE3]
		us_tick && !timer_write && timer == '1 |=> timer == '0)
		else $error("timer did not wrap to zero");

	chk_seconds_count: assert property ( // see [RULE6]
		sec_tick && !bus_wr_in && cal.second < 6'd59
			|=> cal.second == $past(cal.second) + 6'h01)
		else $error("seconds did not advance");

	chk_minute_carry: assert property ( // see [RULE5]
		sec_tick && !bus_wr_in && cal.second == 6'd59 && cal.minute == 6'd59
			|=> cal.minute == 6'h00 && cal.second == 6'h00)
		else $error("minute did not wrap at 59");

	chk_hour_wrap: assert property ( // see [RULE4]
		s_day_end |=> cal.hour == 5'h00)
		else $error("hour did not wrap after 23");

	chk_feb_limit: assert property ( // see [RULE8]
		s_feb_end |=> cal.day == 5'h01 && cal.clock_month_field == 4'd3)
		else $error("february end not taken at 28");

	chk_month_wrap: assert property ( // see [RULE7] see [RULE12]
		s_day_end ##0 cal.clock_month_field == 4'd12 && cal.day == 5'd31
			|=> cal.clock_month_field == 4'h1 && cal.year == $past(cal.year) + 12'h001)
		else $error("year did not advance after december");

	chk_weekday_roll: assert property ( // see [RULE9]
		s_day_end ##0 cal.clock_weekday_field == 3'd6 |=> cal.clock_weekday_field == 3'd0)
		else $error("weekday did not wrap from saturday");

	chk_weekday_recalc: assert property ( // see [RULE10]
		year_write |=> cal.clock_weekday_field == weekday_of(cal.year,
			cal.clock_month_field, cal.day))
		else $error("weekday not recomputed on year write");

	chk_yday_recalc: assert property ( // see [RULE11]
		year_write |=> cal.yday == yday_of(cal.year, cal.clock_month_field, cal.day))
		else $error("day of year not recomputed on year write");

endmodule
`default_nettype wire

// ===== verification/tb.sv
/*
 * Self-checking testbench of the microsecond timer and calendar.
 * Assumes mtc_pkg and mtc_defines.svh are compiled first; no partner model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mtc_defines.svh"

module tb;
	import mtc_pkg::*;

	// ********************************************************************
	// Clock, reset and design instance
	// ********************************************************************
	localparam int US_PER_SEC = 3;

	logic                   mclk_in;
	logic                   srst_in;
	logic [`MTC_ADDR_W-1:0] bus_addr_in;
	logic [31:0]            bus_wdata_in;
	logic                   bus_wr_in;
	logic                   bus_rd_in;
	logic [31:0]            bus_rdata_out;
	logic [31:0]            timer_out;
	mtc_cal_t               calendar_out;
	logic                   us_tick_out;
	logic                   sec_tick_out;
	int                     num_errors;
	int                     checks_done;
	logic [31:0]            seed;

	// A short second keeps every carry chain within a few hundred cycles.
	mtc_top #(.TIMER_W(32), .US_PER_SEC(US_PER_SEC)) dut_u (
		.mclk_in       (mclk_in),
		.srst_in       (srst_in),
		.bus_addr_in   (bus_addr_in),
		.bus_wdata_in  (bus_wdata_in),
		.bus_wr_in     (bus_wr_in),
		.bus_rd_in     (bus_rd_in),
		.bus_rdata_out (bus_rdata_out),
		.timer_out     (timer_out),
		.calendar_out  (calendar_out),
		.us_tick_out   (us_tick_out),
		.sec_tick_out  (sec_tick_out)
	);

	// The 50 MHz system clock.
	always #10 mclk_in = ~mclk_in;

	// ********************************************************************
	// Reference functions
	// ********************************************************************
	// Pseudo-random source with a fixed start, so every run repeats.
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	function automatic int leap(input int y);
		return ((y % 4 == 0) && (y % 100 != 0)) || (y % 400 == 0);
	endfunction

	function automatic int mdays(input int m, input int y);
		case (m)
			2: return 28 + leap(y);
			4, 6, 9, 11: return 30;
			default: return 31;
		endcase
	endfunction

	// Weekday with Sunday as zero, worked out independently of the design.
	function automatic int dow(input int y, input int m, input int d);
		int t[12] = '{0, 3, 2, 5, 0, 3, 5, 1, 4, 6, 2, 4};
		if (m < 3)
			y = y - 1;
		return (y + y / 4 - y / 100 + y / 400 + t[m - 1] + d) % 7;
	endfunction

	function automatic int ydy(input int y, input int m, input int d);
		int n = d;
		for (int k = 1; k < m; k++)
			n = n + mdays(k, y);
		return n;
	endfunction

	function automatic mtc_cal_t mk(input int y, m, d, h, mi, s);
		mtc_cal_t c;
		c.year                = mtc_year_t'(y);
		c.clock_month_field   = mtc_month_t'(m);
		c.day                 = mtc_day_t'(d);
		c.hour                = mtc_hour_t'(h);
		c.minute              = mtc_sixty_t'(mi);
		c.second              = mtc_sixty_t'(s);
		c.clock_weekday_field = mtc_wday_t'(dow(y, m, d));
		c.yday                = mtc_yday_t'(ydy(y, m, d));
		return c;
	endfunction

	// Calendar one second later, with every carry taken in turn.
	function automatic mtc_cal_t nxt(input mtc_cal_t c);
		int y = c.year;
		int m = c.clock_month_field;
		int d = c.day;
		int h = c.hour;
		int mi = c.minute;
		int s = c.second + 1;
		if (s == 60)
		begin
			s = 0;
			mi++;
		end
		if (mi == 60)
		begin
			mi = 0;
			h++;
		end
		if (h == 24)
		begin
			h = 0;
			d++;
		end
		if (d > mdays(m, y))
		begin
			d = 1;
			m++;
		end
		if (m == 13)
		begin
			m = 1;
			y++;
		end
		return mk(y, m, d, h, mi, s);
	endfunction

	function automatic logic [31:0] fld(input logic [7:0] a, input mtc_cal_t c);
		case (a)
			`MTC_OFS_SEC:   return 32'(c.second);
			`MTC_OFS_MIN:   return 32'(c.minute);
			`MTC_OFS_HOUR:  return 32'(c.hour);
			`MTC_OFS_DAY:   return 32'(c.day);
			`MTC_OFS_MONTH: return 32'(c.clock_month_field);
			`MTC_OFS_YEAR:  return 32'(c.year);
			`MTC_OFS_WDAY:  return 32'(c.clock_weekday_field);
			default:        return 32'(c.yday);
		endcase
	endfunction

	// ********************************************************************
	// Bus, wait and check tasks
	// ********************************************************************
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		bus_addr_in  <= a;
		bus_wdata_in <= d;
		bus_wr_in    <= 1'b1;
		@(posedge mclk_in);
		bus_wr_in    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_in);
		bus_addr_in <= a;
		bus_rd_in   <= 1'b1;
		@(posedge mclk_in);
		bus_rd_in   <= 1'b0;
		#1 d = bus_rdata_out;
	endtask

	// Returns after the edge that precedes a tick; n counts the edges waited.
	task automatic sync(input bit sec, output int n);
		for (n = 1; n <= 200; n++)
		begin
			@(posedge mclk_in);
			#1;
			if (sec ? sec_tick_out : us_tick_out)
				return;
		end
		num_errors++;
		final_report();
	endtask

	// ********************************************************************
	// Main sequence
	// ********************************************************************
	initial
	begin
		int       n;
		int       y, m, d;
		logic [31:0] v, r;
		mtc_cal_t e;
		logic [7:0] ofs[8] = '{`MTC_OFS_SEC, `MTC_OFS_MIN, `MTC_OFS_HOUR, `MTC_OFS_DAY,
			`MTC_OFS_MONTH, `MTC_OFS_YEAR, `MTC_OFS_WDAY, `MTC_OFS_YDAY};
		int cy[8] = '{2023, 2024, 2024, 2023, 2100, 2000, 2023, 2024};
		int cm[8] = '{12, 2, 2, 2, 2, 2, 9, 1};
		int cd[8] = '{31, 28, 29, 28, 28, 28, 30, 31};
		mclk_in = 1'b0;
		srst_in = 1'b1;
		bus_addr_in = '0;
		bus_wdata_in = '0;
		bus_wr_in = 1'b0;
		bus_rd_in = 1'b0;
		num_errors = 0;
		checks_done = 0;
		seed = 32'h05f2424a;
		repeat (2) @(posedge mclk_in);
		srst_in <= 1'b0;
		#1 chk(calendar_out, mk(2000, 1, 1, 0, 0, 0));
		chk(timer_out, 32'h0);
		$display("test reset done");

		// Load right after a tick, read back, then watch two ticks 50 cycles apart.
		for (int i = 0; i < 4; i++)
		begin
			seed = xs(seed);
			v = (i == 0) ? 32'hffffffff : (i == 1) ? 32'hfffffffe : seed;
			sync(0, n);
			wr(`MTC_OFS_TIMER, v);
			rd(`MTC_OFS_TIMER, r);
			chk(r, v);
			sync(0, n);
			@(posedge mclk_in);
			#1 chk(timer_out, 32'(v + 32'h1));
			sync(0, n);
			chk(n, `MTC_US_CYCLES - 1);
			@(posedge mclk_in);
			#1 chk($signed(timer_out - v), 2);
		end
		$display("test timer done");

		// Corner dates at the last second of a day, then random dates and times.
		for (int i = 0; i < 16; i++)
		begin
			seed = xs(seed);
			y = (i < 8) ? cy[i] : 1901 + int'(seed[15:0] % 198);
			m = (i < 8) ? cm[i] : 1 + int'(seed[19:16] % 12);
			d = (i < 8) ? cd[i] : 1 + int'(seed[27:20] % mdays(m, y));
			e = (i < 8) ? mk(y, m, d, 23, 59, 59) :
				mk(y, m, d, int'(seed[31:27] % 24), int'(seed[10:5] % 60), int'(seed % 60));
			sync(1, n);
			// The year goes last so the derived fields see the final date.
			for (int k = 0; k < 6; k++)
				wr(ofs[k], fld(ofs[k], e));
			// The year write lands at the edge just passed, so look after it settles.
			#1 chk(calendar_out, e);
			wr(`MTC_OFS_WDAY, 32'(~e.clock_weekday_field));
			for (int k = 0; k < 8; k++)
			begin
				rd(ofs[k], r);
				chk(r, fld(ofs[k], e));
			end
			rd(8'h24, r);
			chk(r, 32'h0);
			sync(1, n);
			@(posedge mclk_in);
			#1 chk(calendar_out, nxt(e));
		end
		$display("test calendar done");
		final_report();
	end
endmodule
`default_nettype wire
